// ==== design/bad_pkg.sv ====
// package of constants and types for the byte alu datapath
package bad_pkg;
	// instruction register offsets (byte addresses)
	localparam logic [7:0] OFS_CMD    = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_FILE   = 8'h0C;
	localparam logic [7:0] OFS_FADDR  = 8'h10;
	localparam logic [7:0] OFS_STAT   = 8'h14;
	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_DST_BIT = 4;
	localparam int CMD_BIT_LSB = 5;
	localparam int CMD_K_LSB   = 8;
	localparam int CMD_F_LSB   = 16;
	// flag bit positions in the arithmetic flags register
	localparam int FLG_CARRY = 0;
	localparam int FLG_DC    = 1;
	localparam int FLG_ZERO  = 2;
	// reset values
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] FILE_RST  = 8'h00;
	// operation codes
	typedef enum logic [3:0] {
		OP_NOP     = 4'h0,
		OP_ADD_LIT = 4'h1,
		OP_ADD_REG = 4'h2,
		OP_AND_LIT = 4'h3,
		OP_AND_REG = 4'h4,
		OP_BIT_CLR = 4'h5,
		OP_BIT_SET = 4'h6,
		OP_BIT_TST = 4'h7
	} bad_op_t;
	// one-hot execution states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SKIP = 3'b100
	} bad_state_t;
endpackage : bad_pkg

// ==== design/bad_file_if.sv ====
// interface carrying file register port signals between datapath and memory
`timescale 1ns/1ps
`default_nettype none
interface bad_file_if #(parameter int AW = 7);
	logic [AW-1:0] addr;
	logic          wrEn;
	logic [7:0]    wrData;
	logic [7:0]    rdData;
	modport master (output addr, output wrEn, output wrData, input rdData);
	modport mem    (input addr, input wrEn, input wrData, output rdData);
endinterface : bad_file_if
`default_nettype wire

// ==== design/bad_file_mem.sv ====
// file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bad_file_mem #(
	parameter int DEPTH = 128
) (
	// clock
	input wire logic clk,
	// memory port
	bad_file_if.mem  port
);
	logic [7:0] memArr [DEPTH];
	logic [7:0] rdData_ff;

	// write and registered read; no reset so it maps onto ram
	always_ff @(posedge clk) begin
		if (port.wrEn) begin
			memArr[port.addr] <= port.wrData;
		end
		// single port: a write is also what the next read returns
		rdData_ff <= port.wrEn ? port.wrData : memArr[port.addr];
	end
	assign port.rdData = rdData_ff;
endmodule : bad_file_mem
`default_nettype wire

// ==== design/bad_datapath.sv ====
// byte alu and bit operation datapath behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - add literal adds 8-bit immediate to accumulator, updates carry, dc, zero
// - add register sums accumulator and file; dest 0 accumulator, 1 file
// - and literal ands immediate into accumulator, only zero flag changes
// - and register ands file, routed by dest select, only zero changes
// - bit clear zeroes selected bit of file register, flags untouched
// - bit set forces selected bit of file register to one, no flags
// - bit test skips next instruction when bit clear, taking two cycles
module bad_datapath
	import bad_pkg::*;
#(
	parameter int FILE_DEPTH = 128
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// datapath state
	output logic      [7:0]  accOut,
	output logic      [7:0]  flagsOut,
	output logic             skipNext
);
	localparam int AW = $clog2(FILE_DEPTH);

	typedef struct packed {
		bad_state_t  state;
		logic        wrPend;
		logic        rdPend;
		logic [7:0]  addr;
		logic [31:0] cmd;
		logic [7:0]  acc;
		logic [7:0]  flags;
		logic [AW-1:0] fAddr;
		logic        skip;
		logic [31:0] rdata;
		logic        ready;
	} bad_regs_t;

	bad_regs_t r_ff;
	bad_regs_t nxt_r;
	bad_file_if #(.AW(AW)) fport ();

	bad_file_mem #(.DEPTH(FILE_DEPTH)) uMem (
		.clk  (clk),
		.port (fport.mem)
	);

	////////////////////////////////////////////////////////////////////////
	bad_op_t       op;
	logic          dst;
	logic [2:0]    bitSel;
	logic [7:0]    kLit;
	logic [AW-1:0] fSel;
	logic [7:0]    operB;
	logic [4:0]    lowSum;
	logic [8:0]    fullSum;
	logic [7:0]    result;
	logic          doAdd;
	logic          doAnd;

	// decode the latched command word
	always_comb begin
		op     = bad_op_t'(r_ff.cmd[CMD_OP_LSB +: 4]);
		dst    = r_ff.cmd[CMD_DST_BIT];
		bitSel = r_ff.cmd[CMD_BIT_LSB +: 3];
		kLit   = r_ff.cmd[CMD_K_LSB +: 8];
		fSel   = r_ff.cmd[CMD_F_LSB +: AW];
	end

	// shared adder: nibble sum gives the digit carry, full sum the carry
	always_comb begin
		operB   = (op == OP_ADD_LIT || op == OP_AND_LIT) ? kLit
			: fport.rdData;
		lowSum  = {1'b0, r_ff.acc[3:0]} + {1'b0, operB[3:0]};
		fullSum = {1'b0, r_ff.acc} + {1'b0, operB};
		doAdd   = (op == OP_ADD_LIT) || (op == OP_ADD_REG);
		doAnd   = (op == OP_AND_LIT) || (op == OP_AND_REG);
		result  = doAdd ? fullSum[7:0] : (r_ff.acc & operB);
	end

	////////////////////////////////////////////////////////////////////////
	// next state: bus slave plus one-cycle execute after the file read
	always_comb begin
		nxt_r          = r_ff;
		nxt_r.ready    = 1'b1;
		fport.addr     = r_ff.fAddr;
		fport.wrEn     = 1'b0;
		fport.wrData   = 8'h00;
		// data phase of a previous write
		if (r_ff.wrPend) begin
			nxt_r.wrPend = 1'b0;
			case (r_ff.addr)
				OFS_CMD: begin
					nxt_r.cmd   = hwdata;
					nxt_r.state = ST_EXEC;
					nxt_r.ready = 1'b0;
					nxt_r.skip  = 1'b0;
				end
				OFS_ACC:   nxt_r.acc   = hwdata[7:0];
				OFS_FLAGS: nxt_r.flags = hwdata[7:0];
				OFS_FADDR: nxt_r.fAddr = hwdata[AW-1:0];
				OFS_FILE: begin
					fport.wrEn   = 1'b1;
					fport.wrData = hwdata[7:0];
				end
				default: ;
			endcase
		end
		// a file address just written steers the memory at once
		fport.addr = nxt_r.fAddr;
		// file read: the registered memory word lands after one wait
		if (r_ff.rdPend) begin
			nxt_r.rdPend = 1'b0;
			nxt_r.rdata  = {24'h000000, fport.rdData};
		end
		// address phase, only while not stalled; register read data
		// here so that it already stands during the data phase
		if (hready && r_ff.ready && hsel && htrans[1]) begin
			nxt_r.addr   = haddr[7:0];
			nxt_r.wrPend = hwrite;
			if (hwrite) begin
				// a command holds its own data phase until executed
				if (haddr[7:0] == OFS_CMD) begin
					nxt_r.ready = 1'b0;
				end
			end else begin
				case (haddr[7:0])
					OFS_ACC:   nxt_r.rdata = {24'h000000, nxt_r.acc};
					OFS_FLAGS: nxt_r.rdata = {24'h000000, nxt_r.flags};
					OFS_FILE: begin
						nxt_r.rdPend = 1'b1;
						nxt_r.ready  = 1'b0;
					end
					OFS_FADDR: nxt_r.rdata = {{(32-AW){1'b0}}, nxt_r.fAddr};
					OFS_STAT:  nxt_r.rdata = {30'h0, nxt_r.skip,
						nxt_r.state != ST_IDLE};
					OFS_CMD:   nxt_r.rdata = nxt_r.cmd;
					default:   nxt_r.rdata = 32'h00000000;
				endcase
			end
		end
		// execute once the file operand has been read
		case (r_ff.state)
			ST_IDLE: ;
			ST_EXEC: begin
				fport.addr  = fSel;
				nxt_r.state = ST_SKIP;
				nxt_r.ready = 1'b0;
			end
			ST_SKIP: begin
				fport.addr  = fSel;
				nxt_r.state = ST_IDLE;
				case (op)
					OP_ADD_LIT, OP_AND_LIT: nxt_r.acc = result;
					OP_ADD_REG, OP_AND_REG: begin
						if (dst) begin
							fport.wrEn   = 1'b1;
							fport.wrData = result;
						end else begin
							nxt_r.acc = result;
						end
					end
					OP_BIT_CLR: begin
						fport.wrEn   = 1'b1;
						fport.wrData = fport.rdData & ~(8'h01 << bitSel);
					end
					OP_BIT_SET: begin
						fport.wrEn   = 1'b1;
						fport.wrData = fport.rdData | (8'h01 << bitSel);
					end
					OP_BIT_TST: nxt_r.skip = ~fport.rdData[bitSel];
					default: ;
				endcase
				// flags: and touches zero only, bit ops touch none
				if (doAdd || doAnd) begin
					nxt_r.flags[FLG_ZERO] = (result == 8'h00);
				end
				if (doAdd) begin
					nxt_r.flags[FLG_CARRY] = fullSum[8];
					nxt_r.flags[FLG_DC]    = lowSum[4];
				end
			end
			default: nxt_r.state = ST_IDLE;
		endcase
		if (!rst_n) begin
			nxt_r       = '0;
			nxt_r.state = ST_IDLE;
			nxt_r.acc   = ACC_RST;
			nxt_r.flags = FLAGS_RST;
			nxt_r.ready = 1'b1;
		end
	end

	// single register stage for the whole state
	always_ff @(posedge clk) begin
		r_ff <= nxt_r;
	end

	// outputs straight from flip-flops, except hresp, which is tied low
	assign hrdata    = r_ff.rdata;
	assign hreadyout = r_ff.ready;
	assign hresp     = 1'b0;
	assign accOut    = r_ff.acc;
	assign flagsOut  = r_ff.flags;
	assign skipNext  = r_ff.skip;
endmodule : bad_datapath
`default_nettype wire

// ==== test/bad_checker.sv ====
// assertions watching the byte alu datapath ports
`timescale 1ns/1ps
`default_nettype none
module bad_checker
	import bad_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	// datapath state
	input wire logic [7:0]  accOut,
	input wire logic [7:0]  flagsOut,
	input wire logic        skipNext
);
	logic            cmdPh_ff;
	logic      [7:0] acc0_ff;
	logic      [7:0] flg0_ff;
	wire logic       take = hsel && htrans[1] && hready && hreadyout;
	wire logic       done = cmdPh_ff && hreadyout;
	wire logic [3:0] op   = hwdata[3:0];
	wire logic [7:0] k    = hwdata[15:8];
	wire logic [8:0] sum  = acc0_ff + k;
	wire logic [4:0] nib  = acc0_ff[3:0] + k[3:0];
	wire logic       addL = done && op == OP_ADD_LIT;
	wire logic       andL = done && op == OP_AND_LIT;
	wire logic       andR = done && op == OP_AND_REG;
	wire logic       regD = done && hwdata[4] && op inside {2, 4};
	wire logic       bitO = done && op inside {5, 6, 7};
	////////////////////////////////////////////////////////////////////
	// state before a command is kept, since the result replaces it
	always_ff @(posedge clk) begin
		if (!rst_n)
			cmdPh_ff <= 1'b0;
		else if (hreadyout)
			cmdPh_ff <= take && hwrite && haddr[7:0] == OFS_CMD;
		if (take) begin
			acc0_ff <= accOut;
			flg0_ff <= flagsOut;
		end
	end
	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_addLit; addL |-> {flagsOut[0], accOut} == sum; endproperty
	a_addLit: assert property (p_addLit) else $error("add lit");
	property p_dc; addL |-> flagsOut[1] == nib[4]; endproperty
	a_dc: assert property (p_dc) else $error("digit carry");
	property p_zero; addL || andL |-> flagsOut[2] == (accOut == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");
	property p_andLit; andL |-> accOut == (acc0_ff & k); endproperty
	a_andLit: assert property (p_andLit) else $error("and lit");
	property p_keep; andL || andR |-> flagsOut[1:0] == flg0_ff[1:0];
	endproperty
	a_keep: assert property (p_keep) else $error("and flags");
	property p_dst; regD |-> accOut == acc0_ff; endproperty
	a_dst: assert property (p_dst) else $error("file dest");
	property p_bit; bitO |-> flagsOut == flg0_ff; endproperty
	a_bit: assert property (p_bit) else $error("bit op flags");
	property p_bitAcc; bitO |-> accOut == acc0_ff; endproperty
	a_bitAcc: assert property (p_bitAcc) else $error("bit op acc");
	property p_skipClr; done && op != OP_BIT_TST |-> !skipNext; endproperty
	a_skipClr: assert property (p_skipClr) else $error("stale skip");
	c_add: cover property (addL && flagsOut[0]);
	c_skip: cover property (done && op == OP_BIT_TST && skipNext);
	c_dst: cover property (regD);
endmodule : bad_checker
bind bad_datapath bad_checker u_chk (.clk, .rst_n, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hreadyout, .accOut, .flagsOut, .skipNext);
`default_nettype wire

// ==== test/bad_seq_model.sv ====
// bus master standing in for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module bad_seq_model (
	// clock and answer
	input  wire logic        clk,
	input  wire logic        hready,
	// request
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [31:0] hwdata
);
	logic [31:0] expQ[$];
	initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
	// ready is sampled at the rising edge, before the slave updates it
	task automatic waitRdy;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
	endtask : waitRdy
	// one single word transfer, each phase held until taken
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		waitRdy();
		htrans <= 2'b00;
		hwdata <= d;
		waitRdy();
		hwdata <= ~d; // stale data never looks valid
	endtask : xfer
endmodule : bad_seq_model
`default_nettype wire

// ==== test/byte_alu_bit_ops_datapath_tb.sv ====
// self-checking bench for the byte alu datapath
`timescale 1ns/1ps
`default_nettype none
module byte_alu_bit_ops_datapath_tb;
	import bad_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        rdPh = 1'b0;
	logic        hsel, hwrite, hreadyout, hresp, skipNext, c, dc, z;
	logic [1:0]  htrans;
	logic [2:0]  b;
	logic [6:0]  fa;
	logic [7:0]  acc, k, fv, accOut, flagsOut;
	logic [31:0] haddr, hwdata, hrdata, r;
	int          mismatches = 0;
	int          n_tests = 0;
	integer      seed = 32'h76497D6D;
	always #25 clk = ~clk;
	bad_datapath dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .accOut, .flagsOut, .skipNext);
	bad_seq_model m (.clk, .hready(hreadyout), .hsel, .haddr, .htrans,
		.hwrite, .hwdata);
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] add(input logic [7:0] x, y);
		logic [8:0] s;
		logic [4:0] n;
		s = x + y;
		n = x[3:0] + y[3:0];
		{c, dc, z} = {s[8], n[4], s[7:0] == 8'h00};
		return s[7:0];
	endfunction : add
	function automatic logic [31:0] fl;
		return {29'h0, z, dc, c};
	endfunction : fl
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		n_tests++;
		if (got !== e) begin
			mismatches++;
			$display("MISMATCH %0t read %h expected %h", $time, got, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		m.xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		m.expQ.push_back(e);
		m.xfer(1'b0, a, 32'h0);
	endtask : rd
	task automatic op(input bad_op_t o, input logic d);
		wr(OFS_CMD, {9'h0, fa, k, b, d, o});
	endtask : op
	task automatic results;
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////
	// read answers are judged where the data phase has settled
	always @(negedge clk) begin
		if (rdPh && hreadyout) begin
			chk(hrdata, m.expQ.pop_front());
			chk({31'h0, hresp}, 32'h0); // response is always okay
		end
		if (hreadyout)
			rdPh = hsel && htrans[1] && !hwrite;
	end
	// watchdog, far beyond the few thousand cycles the run needs
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		results();
	end
	// main sequence: results chain from one command to the next
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		{c, dc, z, acc} = {3'b000, 8'h5A};
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, 32'h0);
		wr(OFS_ACC, {24'h0, acc});
		wr(OFS_FLAGS, 32'h0);
		repeat (24) begin
			r = $random(seed);
			{b, fa, fv, k} = r[25:0];
			wr(OFS_FADDR, {25'h0, fa});
			wr(OFS_FILE, {24'h0, fv});
			acc = add(acc, k);
			op(OP_ADD_LIT, 1'b0);
			rd(OFS_FLAGS, fl());
			fv = add(acc, fv);
			op(OP_ADD_REG, 1'b1);
			rd(OFS_FILE, {24'h0, fv});
			acc = add(acc, fv);
			op(OP_ADD_REG, 1'b0);
			rd(OFS_ACC, {24'h0, acc});
			fv = fv & acc;
			z = fv == 8'h00;
			op(OP_AND_REG, 1'b1);
			rd(OFS_FILE, {24'h0, fv});
			acc = acc & k;
			z = acc == 8'h00;
			op(OP_AND_LIT, 1'b0);
			rd(OFS_FLAGS, fl());
			fv[b] = 1'b1;
			op(OP_BIT_SET, 1'b0);
			op(OP_BIT_TST, 1'b0);
			rd(OFS_STAT, 32'h0);
			fv[b] = 1'b0;
			op(OP_BIT_CLR, 1'b0);
			rd(OFS_FILE, {24'h0, fv});
			op(OP_BIT_TST, 1'b0);
			rd(OFS_STAT, 32'h2);
		end
		results();
	end
endmodule : byte_alu_bit_ops_datapath_tb
`default_nettype wire
